// >>> core/fpp_pkg.sv
/*
 Package for the flash program protection block: key codes, field widths,
 reset values, overlay geometry and timing constants.
 Assumes a 20 MHz system clock.
*/
package fpp_pkg;
    localparam logic [7:0] FPP_KEY_DOWNLOAD = 8'ha5;
    localparam logic [7:0] FPP_KEY_PROGRAM = 8'h5a;
    localparam logic [7:0] FPP_KEY_RESET = 8'h00;
    localparam int FPP_BLOCK_SEL_W = 3;
    localparam int FPP_NUM_BLOCKS = 8;
    localparam int FPP_ADDR_W = 24;
    localparam logic [FPP_BLOCK_SEL_W-1:0] FPP_BLOCK_SEL_RESET = 3'h0;
    localparam logic [FPP_ADDR_W-1:0] FPP_BLOCK_SIZE = 24'h001000;
    localparam logic [FPP_ADDR_W-1:0] FPP_FLASH_BASE = 24'h000000;
    localparam logic [FPP_ADDR_W-1:0] FPP_RAM_BASE = 24'hff0000;
    localparam int FPP_CLOCK_HZ = 20000000;
    localparam int FPP_RESET_HOLD_US = 100;
    localparam int FPP_RESET_HOLD_CYCLES = (FPP_RESET_HOLD_US * (FPP_CLOCK_HZ / 1000000));
    localparam logic [1:0] FPP_OP_NONE = 2'h0;
    localparam logic [1:0] FPP_OP_PROGRAM = 2'h1;
    localparam logic [1:0] FPP_OP_ERASE = 2'h2;
    // Pass/fail result codes
    localparam logic [7:0] FPP_RESULT_PASS = 8'h00;
    localparam logic [7:0] FPP_RESULT_PROTECTED = 8'h01;
    localparam logic [7:0] FPP_RESULT_ERROR = 8'h02;
    localparam logic [7:0] FPP_RESULT_DL_REFUSED = 8'h03;

    typedef enum logic [1:0] {
        FPP_IDLE = 2'b00,
        FPP_BUSY = 2'b01,
        FPP_ERROR = 2'b10
    } fpp_state_type;
endpackage

// >>> core/fpp_sync.sv
/*
 Three-stage input synchroniser with agreement filter.
 Assumes its input may change at any time relative to clock.
*/
`timescale 1ns/100ps
`default_nettype none
module fpp_sync (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Data
    input wire logic din,
    output logic dout
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } fpp_sync_type;

    fpp_sync_type st_r;
    fpp_sync_type st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = din;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        // Stage one only feeds stage two and is not compared; only the later two must agree
        if (st_r.s2 == st_r.s3) begin
            st_nxt.q = st_r.s3;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dout = st_r.q;
endmodule
`default_nettype wire

// >>> core/fpp_overlay.sv
/*
 Overlay address decoder: maps the selected flash block onto on-chip RAM.
 Assumes bus addresses are on the system clock and already registered.
*/
`timescale 1ns/100ps
`default_nettype none
module fpp_overlay
    import fpp_pkg::*;
(
    // Configuration
    input wire logic overlay_enable,
    input wire logic [fpp_pkg::FPP_BLOCK_SEL_W-1:0] overlay_block_select,
    // Address
    input wire logic [fpp_pkg::FPP_ADDR_W-1:0] bus_addr,
    output logic hit_flash_window,
    output logic hit_ram_window,
    output logic [fpp_pkg::FPP_ADDR_W-1:0] ram_addr
);
    logic [FPP_ADDR_W-1:0] block_base;
    logic [FPP_ADDR_W-1:0] offset;

    always_comb begin
        block_base = FPP_FLASH_BASE + FPP_BLOCK_SIZE * {21'h0, overlay_block_select};
        offset = bus_addr - block_base;
        hit_flash_window = overlay_enable && (bus_addr >= block_base)
            && (offset < FPP_BLOCK_SIZE);
        hit_ram_window = overlay_enable && (bus_addr >= FPP_RAM_BASE)
            && ((bus_addr - FPP_RAM_BASE) < FPP_BLOCK_SIZE);
        ram_addr = hit_flash_window ? (FPP_RAM_BASE + offset) : bus_addr;
    end
endmodule
`default_nettype wire

// >>> core/fpp_top.sv
/*
 Flash program protection: hardware, software and error protection of the
 program/erase engine, plus the RAM overlay of one user array block.
 Assumes CPU-side writes arrive as one-cycle strobes on the system clock,
 and that event inputs from other blocks are on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none

module fpp_top
    import fpp_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Key and code control writes
    input wire logic key_write,
    input wire logic [7:0] key_wdata,
    input wire logic trigger_write,
    input wire logic trigger_wdata,
    // Overlay control writes
    input wire logic overlay_write,
    input wire logic overlay_enable_wdata,
    input wire logic [fpp_pkg::FPP_BLOCK_SEL_W-1:0] overlay_block_select_wdata,
    // Mode status
    input wire logic user_mode,
    input wire logic user_program_mode,
    // Operation requests
    input wire logic program_request,
    input wire logic erase_request,
    input wire logic operation_done,
    // Error sources, asynchronous to the clock
    input wire logic interrupt_request,
    input wire logic nmi_request,
    // Error sources from same-clock logic
    input wire logic flash_read,
    input wire logic sleep_execute,
    input wire logic foreign_bus_master,
    // Bus address for overlay
    input wire logic [fpp_pkg::FPP_ADDR_W-1:0] bus_addr,
    // Register views
    output logic [7:0] flash_key_register,
    output logic download_trigger_bit,
    output logic flash_error_flag,
    output logic overlay_enable,
    output logic [fpp_pkg::FPP_BLOCK_SEL_W-1:0] overlay_block_select,
    // Status
    output logic download_start,
    output logic download_allowed,
    output logic program_enable,
    output logic erase_enable,
    output logic operation_busy,
    output logic operation_abort,
    output logic [7:0] pass_fail_result,
    output logic result_valid,
    // Overlay decode
    output logic overlay_flash_hit,
    output logic overlay_ram_hit,
    output logic [fpp_pkg::FPP_ADDR_W-1:0] overlay_ram_addr
);
    // ==========================================================
    // Reset release
    // ==========================================================
    logic [1:0] rst_sync_r;
    logic rst_n;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // ==========================================================
    // Interrupt synchronisers
    // ==========================================================
    logic irq_s;
    logic nmi_s;

    fpp_sync u_sync_irq (
        .clock(clock),
        .rst_n(rst_n),
        .din(interrupt_request),
        .dout(irq_s)
    );

    fpp_sync u_sync_nmi (
        .clock(clock),
        .rst_n(rst_n),
        .din(nmi_request),
        .dout(nmi_s)
    );

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        fpp_state_type state;
        logic [7:0] key;
        logic trigger;
        logic error;
        logic ovl_en;
        logic [FPP_BLOCK_SEL_W-1:0] ovl_sel;
        logic [1:0] op;
        logic dl_start;
        logic abort;
        logic [7:0] result;
        logic result_valid;
    } fpp_top_type;

    fpp_top_type st_r;
    fpp_top_type st_nxt;

    logic dl_ok;
    logic pe_ok;
    logic err_event;
    logic mode_ok;

    always_comb begin
        mode_ok = user_mode || user_program_mode;
        dl_ok = (st_r.key == FPP_KEY_DOWNLOAD) && !st_r.ovl_en && !st_r.error;
        // Program key, trigger, no overlay, no error
        pe_ok = (st_r.key == FPP_KEY_PROGRAM) && st_r.trigger && !st_r.ovl_en
            && !st_r.error;
        err_event = (st_r.state == FPP_BUSY)
            && (irq_s || nmi_s || flash_read || sleep_execute || foreign_bus_master);
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.dl_start = 1'b0;
        st_nxt.abort = 1'b0;
        st_nxt.result_valid = 1'b0;

        if (key_write) begin
            st_nxt.key = key_wdata;
        end
        if (overlay_write && mode_ok) begin
            st_nxt.ovl_en = overlay_enable_wdata;
            st_nxt.ovl_sel = overlay_block_select_wdata;
        end
        if (trigger_write) begin
            if (trigger_wdata && dl_ok) begin
                st_nxt.trigger = 1'b1;
                st_nxt.dl_start = 1'b1;
            end else if (!trigger_wdata) begin
                st_nxt.trigger = 1'b0;
            end
        end

        unique case (st_r.state)
            FPP_IDLE: begin
                if (program_request || erase_request) begin
                    st_nxt.result_valid = 1'b1;
                    if (pe_ok) begin
                        st_nxt.state = FPP_BUSY;
                        st_nxt.op = program_request ? FPP_OP_PROGRAM : FPP_OP_ERASE;
                    end else begin
                        st_nxt.result = st_r.error ? FPP_RESULT_ERROR : FPP_RESULT_PROTECTED;
                    end
                end
            end
            FPP_BUSY: begin
                if (err_event) begin
                    st_nxt.error = 1'b1;
                    st_nxt.abort = 1'b1;
                    st_nxt.state = FPP_ERROR;
                    st_nxt.op = FPP_OP_NONE;
                    st_nxt.result = FPP_RESULT_ERROR;
                    st_nxt.result_valid = 1'b1;
                end else if (operation_done) begin
                    st_nxt.state = FPP_IDLE;
                    st_nxt.op = FPP_OP_NONE;
                    st_nxt.result = FPP_RESULT_PASS;
                    st_nxt.result_valid = 1'b1;
                end
            end
            FPP_ERROR: begin
                st_nxt.state = FPP_ERROR;
                if (program_request || erase_request) begin
                    st_nxt.result = FPP_RESULT_ERROR;
                    st_nxt.result_valid = 1'b1;
                end
            end
            default: begin
                st_nxt.state = FPP_ERROR;
                st_nxt.error = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r.state <= FPP_IDLE;
            st_r.key <= FPP_KEY_RESET;
            st_r.trigger <= 1'b0;
            st_r.error <= 1'b0;
            st_r.ovl_en <= 1'b0;
            st_r.ovl_sel <= FPP_BLOCK_SEL_RESET;
            st_r.op <= FPP_OP_NONE;
            st_r.dl_start <= 1'b0;
            st_r.abort <= 1'b0;
            st_r.result <= FPP_RESULT_PASS;
            st_r.result_valid <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // Overlay decode
    // ==========================================================
    fpp_overlay u_overlay (
        .overlay_enable(st_r.ovl_en),
        .overlay_block_select(st_r.ovl_sel),
        .bus_addr(bus_addr),
        .hit_flash_window(overlay_flash_hit),
        .hit_ram_window(overlay_ram_hit),
        .ram_addr(overlay_ram_addr)
    );

    // ==========================================================
    // Outputs
    // ==========================================================
    assign flash_key_register = st_r.key;
    assign download_trigger_bit = st_r.trigger;
    assign flash_error_flag = st_r.error;
    assign overlay_enable = st_r.ovl_en;
    assign overlay_block_select = st_r.ovl_sel;
    assign download_start = st_r.dl_start;
    assign download_allowed = dl_ok;
    // Overlay set mid-operation also drops them, so emulation never programs
    assign program_enable = (st_r.op == FPP_OP_PROGRAM) && (st_r.state == FPP_BUSY)
        && !st_r.ovl_en;
    assign erase_enable = (st_r.op == FPP_OP_ERASE) && (st_r.state == FPP_BUSY)
        && !st_r.ovl_en;
    assign operation_busy = (st_r.state == FPP_BUSY);
    assign operation_abort = st_r.abort;
    assign pass_fail_result = st_r.result;
    assign result_valid = st_r.result_valid;
endmodule
`default_nettype wire

// >>> verification/fpp_top_monitor.sv
/* Checker for fpp_top: protection and overlay relations seen at its ports.
 Assumes one clock domain and the active-low reset rstn. */
`timescale 1ns/100ps
`default_nettype none
module fpp_top_monitor
    import fpp_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Requests and events
    input wire logic program_request,
    input wire logic operation_done,
    input wire logic interrupt_request,
    input wire logic nmi_request,
    input wire logic flash_read,
    input wire logic sleep_execute,
    input wire logic foreign_bus_master,
    input wire logic [fpp_pkg::FPP_ADDR_W-1:0] bus_addr,
    // Block outputs
    input wire logic [7:0] flash_key_register,
    input wire logic flash_error_flag,
    input wire logic overlay_enable,
    input wire logic [fpp_pkg::FPP_BLOCK_SEL_W-1:0] overlay_block_select,
    input wire logic download_start,
    input wire logic download_allowed,
    input wire logic program_enable,
    input wire logic erase_enable,
    input wire logic operation_busy,
    input wire logic operation_abort,
    input wire logic [7:0] pass_fail_result,
    input wire logic result_valid,
    input wire logic overlay_flash_hit
);
    // ========
    // Assertions
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);
    // A done in the same cycle is left out, although in the block the error wins over it
    property p_err(src);
        operation_busy && src && !operation_done |=> operation_abort && flash_error_flag;
    endproperty
    a_abort_sets_flag: assert property (operation_abort |-> flash_error_flag)
        else $error("abort without error flag");
    a_flag_sticky: assert property (flash_error_flag |=> flash_error_flag)
        else $error("error flag cleared without reset");
    a_read_aborts: assert property (p_err(flash_read))
        else $error("flash read during operation not aborted");
    a_sleep_aborts: assert property (p_err(sleep_execute))
        else $error("sleep during operation not aborted");
    a_master_aborts: assert property (p_err(foreign_bus_master))
        else $error("foreign master during operation not aborted");
    // Interrupts pass a synchroniser, so a window is allowed
    a_irq_aborts: assert property (operation_busy && !operation_done &&
        (interrupt_request || nmi_request) |-> ##[1:6] flash_error_flag)
        else $error("interrupt during operation not aborted");
    a_nokey_refused: assert property (!operation_busy && !flash_error_flag &&
        program_request && flash_key_register != FPP_KEY_PROGRAM
        |=> result_valid && pass_fail_result == FPP_RESULT_PROTECTED)
        else $error("request without key not refused");
    a_error_refused: assert property (flash_error_flag && program_request
        |=> result_valid && !operation_busy && pass_fail_result == FPP_RESULT_ERROR)
        else $error("request in error state not refused");
    a_overlay_locks: assert property (overlay_enable
        |-> !download_allowed && !program_enable && !erase_enable)
        else $error("overlay enabled but not protected");
    a_one_block: assert property (overlay_flash_hit |-> overlay_enable &&
        bus_addr[23:15] == 9'h000 && bus_addr[14:12] == overlay_block_select)
        else $error("overlay hit outside selected block");
    a_dl_needs_key: assert property (download_start |-> $past(download_allowed))
        else $error("download started without download key");
    c_download: cover property (download_start);
    c_abort: cover property (operation_abort);
    c_overlay: cover property (overlay_flash_hit);
endmodule
bind fpp_top fpp_top_monitor i_mon (.clock, .rstn, .program_request, .operation_done,
    .interrupt_request, .nmi_request, .flash_read, .sleep_execute, .foreign_bus_master,
    .bus_addr, .flash_key_register, .flash_error_flag, .overlay_enable,
    .overlay_block_select, .download_start, .download_allowed, .program_enable,
    .erase_enable, .operation_busy, .operation_abort, .pass_fail_result, .result_valid,
    .overlay_flash_hit);
`default_nettype wire

// >>> verification/test_flash_program_protection.sv
/* Testbench for fpp_top: drives strobes and events at the falling edge.
 Assumes the 20 MHz clock and the two-flop reset release of the block. */
`timescale 1ns/100ps
`default_nettype none
module test_flash_program_protection;
    import fpp_pkg::*;
    logic clock = 1'b0, rstn = 1'b0;
    logic key_write = 1'b0, trigger_write = 1'b0, trigger_wdata = 1'b0;
    logic overlay_write = 1'b0, overlay_enable_wdata = 1'b0;
    logic user_mode = 1'b0, user_program_mode = 1'b0;
    logic program_request = 1'b0, erase_request = 1'b0, operation_done = 1'b0;
    logic [7:0] key_wdata = 8'h00;
    logic [FPP_BLOCK_SEL_W-1:0] overlay_block_select_wdata = 3'h0;
    logic [FPP_ADDR_W-1:0] bus_addr = 24'h000000;
    logic [4:0] err_src = 5'h00;
    logic interrupt_request, nmi_request, flash_read, sleep_execute, foreign_bus_master;
    logic [7:0] flash_key_register, pass_fail_result;
    logic download_trigger_bit, flash_error_flag, overlay_enable, download_start;
    logic download_allowed, program_enable, erase_enable, operation_busy;
    logic operation_abort, result_valid, overlay_flash_hit, overlay_ram_hit;
    logic [FPP_BLOCK_SEL_W-1:0] overlay_block_select;
    logic [FPP_ADDR_W-1:0] overlay_ram_addr;
    int fails = 0, comparisons = 0;
    assign {nmi_request, interrupt_request} = err_src[4:3];
    assign {foreign_bus_master, sleep_execute, flash_read} = err_src[2:0];
    always #25 clock = ~clock;
    fpp_top i_dut (.clock, .rstn, .key_write, .key_wdata, .trigger_write, .trigger_wdata,
        .overlay_write, .overlay_enable_wdata, .overlay_block_select_wdata, .user_mode,
        .user_program_mode, .program_request, .erase_request, .operation_done,
        .interrupt_request, .nmi_request, .flash_read, .sleep_execute,
        .foreign_bus_master, .bus_addr, .flash_key_register, .download_trigger_bit,
        .flash_error_flag, .overlay_enable, .overlay_block_select, .download_start,
        .download_allowed, .program_enable, .erase_enable, .operation_busy,
        .operation_abort, .pass_fail_result, .result_valid, .overlay_flash_hit,
        .overlay_ram_hit, .overlay_ram_addr);
    // ========
    // Access tasks
    task automatic tally_and_finish;
        if (fails == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask
    // Two cycles low, then wait out the two-flop release
    task automatic do_reset;
        rstn = 1'b0;
        tick(2);
        rstn = 1'b1;
        tick(3);
    endtask
    task automatic write_key(input logic [7:0] k);
        key_write = 1'b1;
        key_wdata = k;
        tick(1);
        key_write = 1'b0;
    endtask
    task automatic write_trig(input logic v);
        trigger_write = 1'b1;
        trigger_wdata = v;
        tick(1);
        trigger_write = 1'b0;
    endtask
    task automatic write_ovl(input logic en, input logic [2:0] sel);
        overlay_write = 1'b1;
        overlay_enable_wdata = en;
        overlay_block_select_wdata = sel;
        tick(1);
        overlay_write = 1'b0;
    endtask
    task automatic req(input logic e);
        program_request = !e;
        erase_request = e;
        tick(1);
        program_request = 1'b0;
        erase_request = 1'b0;
    endtask
    task automatic chk_result(input logic [7:0] exp);
        chk("result_valid", 24'h1, {23'h0, result_valid});
        chk("pass_fail_result", {16'h0, exp}, {16'h0, pass_fail_result});
    endtask
    task automatic start_op(input logic e);
        write_key(FPP_KEY_DOWNLOAD);
        write_trig(1'b1);
        chk("download_start", 24'h1, {23'h0, download_start});
        write_key(FPP_KEY_PROGRAM);
        req(e);
        chk("operation_busy", 24'h1, {23'h0, operation_busy});
        chk("enable", 24'h1, {23'h0, e ? erase_enable : program_enable});
    endtask
    // ========
    // Scenarios
    initial begin
        do_reset;
        chk("flash_key_register", 24'h0, {16'h0, flash_key_register});
        req(1'b1);
        chk_result(FPP_RESULT_PROTECTED);
        write_key(FPP_KEY_PROGRAM);
        write_trig(1'b1);
        chk("download_trigger_bit", 24'h0, {23'h0, download_trigger_bit});
        write_key(FPP_KEY_DOWNLOAD);
        write_trig(1'b1);
        write_trig(1'b0);
        write_key(FPP_KEY_PROGRAM);
        req(1'b0);
        chk_result(FPP_RESULT_PROTECTED);
        for (int e = 0; e < 2; e++) begin
            start_op(e[0]);
            operation_done = 1'b1;
            tick(1);
            operation_done = 1'b0;
            chk_result(FPP_RESULT_PASS);
        end
        start_op(1'b0);
        do_reset;
        chk("operation_busy", 24'h0, {23'h0, operation_busy});
        write_ovl(1'b1, 3'h3);
        chk("overlay_enable", 24'h0, {23'h0, overlay_enable});
        user_program_mode = 1'b1;
        for (int s = 0; s < 8; s++) begin
            write_ovl(1'b1, s[2:0]);
            chk("overlay_block_select", s, {21'h0, overlay_block_select});
            bus_addr = s * FPP_BLOCK_SIZE + 24'h10;
            #1;
            chk("overlay_flash_hit", 24'h1, {23'h0, overlay_flash_hit});
            chk("overlay_ram_addr", FPP_RAM_BASE + 24'h10, overlay_ram_addr);
            bus_addr = ((s + 1) % 8) * FPP_BLOCK_SIZE;
            #1;
            chk("overlay_flash_hit", 24'h0, {23'h0, overlay_flash_hit});
            bus_addr = FPP_RAM_BASE + 24'h10;
            #1;
            chk("overlay_ram_hit", 24'h1, {23'h0, overlay_ram_hit});
        end
        user_program_mode = 1'b0;
        user_mode = 1'b1;
        write_ovl(1'b1, 3'h0);
        chk("overlay_enable", 24'h1, {23'h0, overlay_enable});
        write_key(FPP_KEY_DOWNLOAD);
        write_trig(1'b1);
        chk("download_start", 24'h0, {23'h0, download_start});
        write_key(FPP_KEY_PROGRAM);
        req(1'b1);
        chk_result(FPP_RESULT_PROTECTED);
        write_ovl(1'b0, 3'h0);
        write_key(FPP_KEY_DOWNLOAD);
        write_trig(1'b1);
        chk("download_start", 24'h1, {23'h0, download_start});
        write_key(FPP_KEY_PROGRAM);
        req(1'b0);
        chk("program_enable", 24'h1, {23'h0, program_enable});
        write_ovl(1'b1, 3'h0);
        chk("program_enable", 24'h0, {23'h0, program_enable});
        // Each error source in turn, with a fresh reset before it
        for (int i = 0; i < 5; i++) begin
            do_reset;
            start_op(i == 1);
            err_src = 5'h01 << i;
            for (int n = 0; n < 8 && flash_error_flag !== 1'b1; n++) begin
                tick(1);
            end
            if (flash_error_flag !== 1'b1) begin
                fails++;
                tally_and_finish;
            end
            chk("operation_abort", 24'h1, {23'h0, operation_abort});
            chk_result(FPP_RESULT_ERROR);
            err_src = 5'h00;
            req(1'b0);
            chk_result(FPP_RESULT_ERROR);
            chk("operation_busy", 24'h0, {23'h0, operation_busy});
        end
        do_reset;
        chk("flash_error_flag", 24'h0, {23'h0, flash_error_flag});
        tally_and_finish;
    end
endmodule
`default_nettype wire
